// *** core/mic_config.sv ***
// Interrupt settings, axis enables and thresholds of a three-axis magnetometer.
// Assumes register port and measurement results come from logic on clk_sys.
`default_nettype none
// Behaviour
// - Interrupt enable bit 7 gates data overrun into status bit 7.
// - Interrupt enable bit 6 routes overflow status onto the interrupt pin.
// - Interrupt enable bits 5..3, active low, enable high-limit detection z/y/x.
// - Interrupt enable bits 2..0, active low, enable low-limit detection z/y/x.
// - A disabled channel keeps its last value in the data outputs.
// - Disabling z also disables resistance, forcing its output to zero.
// - Detection on a disabled axis still runs on its stored value.
// - Axis register bit 7 maps data-ready status onto data_ready_pin.
// - Axis register bit 6 maps interrupt status onto the interrupt pin.
// - Axis register bits 5..3, active low, enable z/y/x channels.
// - Axis register bit 2 selects data_ready_pin polarity, 1 active high.
// - Axis register bit 1 latches interrupt until status register is read.
// - Axis register bit 0 selects interrupt pin polarity, 1 active high.
// - Host writes the 8-bit low limit; device detects against it.
// - Host writes the 8-bit high limit; device detects against it.
// - Status holds overrun, overflow, high z/y/x, low z/y/x flags.
module mic_config
  import mic_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic measDone,
  input wire mic_meas_t measIn,
  input wire logic dataRead,
  output mic_data_t dataOut,
  output logic dataReadyPin,
  output logic intPin
);
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] intEn_r;
  logic [7:0] axisCfg_r;
  logic [7:0] lowLimitValue_r;
  logic [7:0] highLimitValue_r;
  logic wrIntEn;
  logic wrAxis;
  logic wrLow;
  logic wrHigh;
  logic rdStatus;

  always_comb begin
    wrIntEn = 1'b0;
    wrAxis = 1'b0;
    wrLow = 1'b0;
    wrHigh = 1'b0;
    if (regWrite && regAddr == MIC_ADDR_INT_EN) begin
      wrIntEn = 1'b1;
    end else if (regWrite && regAddr == MIC_ADDR_AXIS) begin
      wrAxis = 1'b1;
    end else if (regWrite && regAddr == MIC_ADDR_LOW) begin
      wrLow = 1'b1;
    end else if (regWrite && regAddr == MIC_ADDR_HIGH) begin
      wrHigh = 1'b1;
    end
  end

  assign rdStatus = regRead && regAddr == MIC_ADDR_STATUS;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      intEn_r <= MIC_INT_EN_RST;
      axisCfg_r <= MIC_AXIS_RST;
      lowLimitValue_r <= MIC_LOW_RST;
      highLimitValue_r <= MIC_HIGH_RST;
    end else begin
      if (wrIntEn) begin
        intEn_r <= regWdata;
      end
      if (wrAxis) begin
        axisCfg_r <= regWdata;
      end
      if (wrLow) begin
        lowLimitValue_r <= regWdata;
      end
      if (wrHigh) begin
        highLimitValue_r <= regWdata;
      end
    end
  end

  // ----------------------------------------
  // Measured data store
  // ----------------------------------------
  mic_data_t data_r;
  mic_data_t data_nxt;
  logic [MIC_AXES-1:0] chanOn;
  logic signed [7:0] axisNew [MIC_AXES];
  logic signed [7:0] axisOld [MIC_AXES];
  logic signed [7:0] axisUse [MIC_AXES];
  logic [MIC_AXES-1:0] lowHit;
  logic [MIC_AXES-1:0] highHit;

  assign axisNew[0] = measIn.x;
  assign axisNew[1] = measIn.y;
  assign axisNew[2] = measIn.z;
  assign axisOld[0] = data_r.x;
  assign axisOld[1] = data_r.y;
  assign axisOld[2] = data_r.z;

  genvar gi;
  generate
    for (gi = 0; gi < MIC_AXES; gi++) begin : gAxis
      assign chanOn[gi] = !axisCfg_r[MIC_B_CHAN+gi];
      assign axisUse[gi] = chanOn[gi] ? axisNew[gi] : axisOld[gi];
      assign lowHit[gi] = !intEn_r[MIC_B_LOW+gi] &&
                          (axisUse[gi] < $signed(lowLimitValue_r));
      assign highHit[gi] = !intEn_r[MIC_B_HIGH+gi] &&
                           (axisUse[gi] > $signed(highLimitValue_r));
    end
  endgenerate

  always_comb begin
    data_nxt.x = axisUse[0];
    data_nxt.y = axisUse[1];
    data_nxt.z = axisUse[2];
    data_nxt.res = chanOn[2] ? measIn.res : MIC_RES_ZERO;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_r <= '0;
    end else if (measDone) begin
      data_r <= data_nxt;
    end
  end

  assign dataOut = data_r;

  // ----------------------------------------
  // Data ready and status flags
  // ----------------------------------------
  logic data_ready_pin_r;
  logic [7:0] status_r;
  logic [7:0] event_s;
  logic latched;

  assign latched = axisCfg_r[MIC_B_LATCH];

  always_comb begin
    event_s = MIC_ZERO8;
    event_s[MIC_B_OVR] = intEn_r[MIC_B_OVR] && data_ready_pin_r;
    event_s[MIC_B_OVF] = measIn.ovf;
    event_s[MIC_B_HIGH +: MIC_AXES] = highHit;
    event_s[MIC_B_LOW +: MIC_AXES] = lowHit;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_ready_pin_r <= 1'b0;
    end else if (measDone) begin
      data_ready_pin_r <= 1'b1;
    end else if (dataRead) begin
      data_ready_pin_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= MIC_ZERO8;
    end else if (measDone && !latched) begin
      status_r <= event_s;
    end else if (measDone) begin
      status_r <= status_r | event_s;
    end else if (rdStatus && latched) begin
      status_r <= MIC_ZERO8;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  logic intActive;
  logic intPin_r;
  logic dataReadyPin_r;

  assign intActive = axisCfg_r[MIC_B_INT_EN] &&
                     ((|status_r[MIC_B_HIGH +: MIC_AXES]) ||
                      (|status_r[MIC_B_LOW +: MIC_AXES]) ||
                      (intEn_r[MIC_B_OVF] && status_r[MIC_B_OVF]));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      intPin_r <= 1'b0;
    end else begin
      intPin_r <= intActive == axisCfg_r[MIC_B_INT_POL];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dataReadyPin_r <= 1'b0;
    end else begin
      dataReadyPin_r <= (axisCfg_r[MIC_B_DATA_READY_PIN_EN] && data_ready_pin_r) ==
                        axisCfg_r[MIC_B_DATA_READY_PIN_POL];
    end
  end

  assign intPin = intPin_r;
  assign dataReadyPin = dataReadyPin_r;

  // ----------------------------------------
  // Register read-back
  // ----------------------------------------
  logic [7:0] regRdata_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      regRdata_r <= MIC_ZERO8;
    end else if (regRead) begin
      if (regAddr == MIC_ADDR_STATUS) begin
        regRdata_r <= status_r;
      end else if (regAddr == MIC_ADDR_INT_EN) begin
        regRdata_r <= intEn_r;
      end else if (regAddr == MIC_ADDR_AXIS) begin
        regRdata_r <= axisCfg_r;
      end else if (regAddr == MIC_ADDR_LOW) begin
        regRdata_r <= lowLimitValue_r;
      end else if (regAddr == MIC_ADDR_HIGH) begin
        regRdata_r <= highLimitValue_r;
      end else begin
        regRdata_r <= MIC_ZERO8;
      end
    end
  end

  assign regRdata = regRdata_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  a_overrun_gate: assert property (
    $rose(status_r[MIC_B_OVR]) |-> $past(intEn_r[MIC_B_OVR]) && $past(data_ready_pin_r)
  ) else $error("Overrun flag set while overrun report disabled");

  a_overflow_route: assert property (
    intActive && !(|status_r[5:0]) |-> intEn_r[MIC_B_OVF] && status_r[MIC_B_OVF]
  ) else $error("Interrupt active without a routed source");

  a_high_gate: assert property (
    measDone && intEn_r[MIC_B_HIGH] |=> !latched || $past(!latched) ||
    status_r[MIC_B_HIGH] == $past(status_r[MIC_B_HIGH])
  ) else $error("High x flag changed while its detection disabled");

  a_low_gate: assert property (
    measDone && !latched && intEn_r[MIC_B_LOW] |=> !status_r[MIC_B_LOW]
  ) else $error("Low x flag set while its detection disabled");

  a_hold_disabled: assert property (
    measDone && axisCfg_r[MIC_B_CHAN] |=> dataOut.x == $past(dataOut.x)
  ) else $error("Disabled x channel changed its data");

  a_res_zero: assert property (
    measDone && axisCfg_r[MIC_B_CHAN+2] |=> dataOut.res == MIC_RES_ZERO
  ) else $error("Resistance not zero with z disabled");

  a_stored_compare: assert property (
    measDone && !latched && axisCfg_r[MIC_B_CHAN+2] && !intEn_r[MIC_B_LOW+2] &&
    data_r.z < $signed(lowLimitValue_r) |=> status_r[MIC_B_LOW+2]
  ) else $error("Stored z value not compared");

  a_data_ready_pin_off: assert property (
    !axisCfg_r[MIC_B_DATA_READY_PIN_EN] [*2] |-> dataReadyPin == !$past(axisCfg_r[MIC_B_DATA_READY_PIN_POL])
  ) else $error("Data ready pin active while unmapped");

  a_int_off: assert property (
    !axisCfg_r[MIC_B_INT_EN] [*2] |-> intPin == !$past(axisCfg_r[MIC_B_INT_POL])
  ) else $error("Interrupt pin active while unmapped");

  a_latch_hold: assert property (
    latched && |status_r && !rdStatus && !measDone |=> status_r == $past(status_r)
  ) else $error("Latched flags changed without a status read");

  a_read_back: assert property (
    regRead && regAddr == MIC_ADDR_INT_EN |=> regRdata == $past(intEn_r)
  ) else $error("Interrupt enable read-back wrong");

  a_low_write: assert property (
    wrLow |=> lowLimitValue_r == $past(regWdata)
  ) else $error("Low limit write lost");

  a_high_write: assert property (
    wrHigh |=> highLimitValue_r == $past(regWdata)
  ) else $error("High limit write lost");

  a_axis_write: assert property (
    wrAxis |=> axisCfg_r == $past(regWdata)
  ) else $error("Axis register write lost");

  a_chan_update: assert property (
    measDone && !axisCfg_r[MIC_B_CHAN] |=> dataOut.x == $past(measIn.x)
  ) else $error("Enabled x channel not updated");

  a_res_live: assert property (
    measDone && !axisCfg_r[MIC_B_CHAN+2] |=> dataOut.res == $past(measIn.res)
  ) else $error("Resistance not updated with z enabled");

  a_ovf_record: assert property (
    measDone && !latched |=> status_r[MIC_B_OVF] == $past(measIn.ovf)
  ) else $error("Overflow flag does not follow measurement");

  a_high_detect: assert property (
    measDone && !axisCfg_r[MIC_B_CHAN+2] && !intEn_r[MIC_B_HIGH+2] &&
    measIn.z > $signed(highLimitValue_r) |=> status_r[MIC_B_HIGH+2]
  ) else $error("High z crossing not flagged");

  a_low_detect: assert property (
    measDone && !axisCfg_r[MIC_B_CHAN+1] && !intEn_r[MIC_B_LOW+1] &&
    measIn.y < $signed(lowLimitValue_r) |=> status_r[MIC_B_LOW+1]
  ) else $error("Low y crossing not flagged");

  a_data_ready_pin_on: assert property (
    axisCfg_r[MIC_B_DATA_READY_PIN_EN] && data_ready_pin_r |=> dataReadyPin == $past(axisCfg_r[MIC_B_DATA_READY_PIN_POL])
  ) else $error("Data ready pin level wrong while active");

  a_int_on: assert property (
    intActive |=> intPin == $past(axisCfg_r[MIC_B_INT_POL])
  ) else $error("Interrupt pin level wrong while active");

  a_latch_clear: assert property (
    rdStatus && latched && !measDone |=> status_r == MIC_ZERO8
  ) else $error("Latched flags not cleared by status read");

  a_status_ro: assert property (
    regWrite && regAddr == MIC_ADDR_STATUS && !measDone && !rdStatus |=> status_r == $past(status_r)
  ) else $error("Status changed by a host write");

  c_int_fire: cover property (measDone ##1 intActive);
  c_res_zero: cover property (measDone && axisCfg_r[MIC_B_CHAN+2]);
  c_overflow_int: cover property (intActive && status_r[MIC_B_OVF]);
  c_latched_clear: cover property (latched && |status_r && rdStatus ##1 status_r == MIC_ZERO8);
  c_overrun: cover property ($rose(status_r[MIC_B_OVR]));
endmodule
`default_nettype wire

// *** inc/mic_pkg.sv ***
// Constants and carrier types for the magnetometer interrupt/axis config block.
// Assumes a single clk_sys domain shared by the register port and the datapath.
`default_nettype none
package mic_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] MIC_ADDR_STATUS = 8'h4a;
  localparam logic [7:0] MIC_ADDR_INT_EN = 8'h4d;
  localparam logic [7:0] MIC_ADDR_AXIS = 8'h4e;
  localparam logic [7:0] MIC_ADDR_LOW = 8'h4f;
  localparam logic [7:0] MIC_ADDR_HIGH = 8'h50;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] MIC_INT_EN_RST = 8'h3f;
  localparam logic [7:0] MIC_AXIS_RST = 8'h07;
  localparam logic [7:0] MIC_LOW_RST = 8'h00;
  localparam logic [7:0] MIC_HIGH_RST = 8'h00;
  localparam logic [7:0] MIC_ZERO8 = 8'h00;
  localparam logic [13:0] MIC_RES_ZERO = 14'h0000;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MIC_B_OVR = 7;
  localparam int MIC_B_OVF = 6;
  localparam int MIC_B_HIGH = 3;
  localparam int MIC_B_LOW = 0;
  localparam int MIC_B_DATA_READY_PIN_EN = 7;
  localparam int MIC_B_INT_EN = 6;
  localparam int MIC_B_CHAN = 3;
  localparam int MIC_B_DATA_READY_PIN_POL = 2;
  localparam int MIC_B_LATCH = 1;
  localparam int MIC_B_INT_POL = 0;
  localparam int MIC_AXES = 3;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic signed [7:0] z;
    logic signed [7:0] y;
    logic signed [7:0] x;
    logic [13:0] res;
    logic ovf;
  } mic_meas_t;
  typedef struct packed {
    logic signed [7:0] z;
    logic signed [7:0] y;
    logic signed [7:0] x;
    logic [13:0] res;
  } mic_data_t;
endpackage
`default_nettype wire

// *** tb/magnetometer_int_axis_config_tb_top.sv ***
// Self-checking bench for the interrupt and axis configuration block.
// Assumes mic_pkg and mic_host_model are compiled first.
`default_nettype none
module magnetometer_int_axis_config_tb_top import mic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] ie, ax, lo, hi, z, y, x;
    logic ovf;
    logic [7:0] st;
    logic ip;
  } mic_row_t;
  logic clk_sys, reset_n, regWrite, regRead, measDone, dataRead, dataReadyPin, intPin;
  logic [7:0] regAddr, regWdata, regRdata, d;
  logic signed [7:0] lastZ, lastX, lastY;
  mic_meas_t measIn;
  mic_data_t dataOut;
  int fails = 0;
  int checksDone = 0;
  int cycles = 0;
  mic_row_t rows [6] = '{
    '{8'h00, 8'hc7, 8'hf0, 8'h10, 8'h14, 8'hec, 8'h00, 1'b0, 8'h22, 1'b1},
    '{8'h3f, 8'h47, 8'hf0, 8'h10, 8'h00, 8'h00, 8'h00, 1'b1, 8'h40, 1'b0},
    '{8'h7f, 8'hc2, 8'hf0, 8'h10, 8'h00, 8'h00, 8'h00, 1'b1, 8'h40, 1'b0},
    '{8'h3e, 8'h01, 8'h00, 8'h10, 8'h00, 8'h00, 8'hff, 1'b0, 8'h01, 1'b0},
    '{8'h37, 8'h41, 8'h00, 8'h7f, 8'h00, 8'h00, 8'h7f, 1'b0, 8'h00, 1'b0},
    '{8'h3b, 8'h69, 8'h05, 8'h7f, 8'h64, 8'h00, 8'h00, 1'b0, 8'h04, 1'b1}};
  mic_config uut (.clk_sys(clk_sys), .reset_n(reset_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .measDone(measDone), .measIn(measIn), .dataRead(dataRead), .dataOut(dataOut),
    .dataReadyPin(dataReadyPin), .intPin(intPin));
  mic_host_model host (.clk_sys(clk_sys), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic meas(input mic_row_t r);
    @(posedge clk_sys);
    measDone <= 1'b1;
    measIn <= {r.z, r.y, r.x, 14'h0abc, r.ovf};
    @(posedge clk_sys);
    measDone <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic pulseRead();
    @(posedge clk_sys);
    dataRead <= 1'b1;
    @(posedge clk_sys);
    dataRead <= 1'b0;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    measDone = 1'b0;
    measIn = '0;
    dataRead = 1'b0;
    lastZ = 8'sh00;
    lastX = 8'sh00;
    lastY = 8'sh00;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    host.rd(MIC_ADDR_INT_EN, d);
    chk(d, 8'h3f);
    host.rd(MIC_ADDR_AXIS, d);
    chk(d, 8'h07);
    chk({intPin, dataReadyPin}, 2'b00);
    host.rd(8'h51, d);
    chk(d, 8'h00);
    foreach (rows[i]) begin
      host.wr(MIC_ADDR_INT_EN, rows[i].ie);
      host.wr(MIC_ADDR_AXIS, rows[i].ax);
      host.wr(MIC_ADDR_LOW, rows[i].lo);
      host.wr(MIC_ADDR_HIGH, rows[i].hi);
      host.rd(MIC_ADDR_LOW, d);
      chk(d, rows[i].lo);
      host.rd(MIC_ADDR_HIGH, d);
      chk(d, rows[i].hi);
      if (!rows[i].ax[5]) lastZ = rows[i].z;
      if (!rows[i].ax[4]) lastY = rows[i].y;
      if (!rows[i].ax[3]) lastX = rows[i].x;
      meas(rows[i]);
      chk(intPin, rows[i].ip);
      chk(dataReadyPin, rows[i].ax[7] ? rows[i].ax[2] : !rows[i].ax[2]);
      chk(dataOut.z, lastZ);
      chk(dataOut.y, lastY);
      chk(dataOut.x, lastX);
      chk(dataOut.res, rows[i].ax[5] ? 14'h0000 : 14'h0abc);
      host.rd(MIC_ADDR_STATUS, d);
      chk(d, rows[i].st);
      @(posedge clk_sys);
      #1;
      chk(intPin, rows[i].ax[1] ? !rows[i].ax[0] : rows[i].ip);
      pulseRead();
      @(posedge clk_sys);
      #1;
      chk(dataReadyPin, !rows[i].ax[2]);
    end
    // Overrun: second result before the first was read
    host.wr(MIC_ADDR_INT_EN, 8'hbf);
    meas(rows[4]);
    meas(rows[4]);
    host.rd(MIC_ADDR_STATUS, d);
    chk(d, 8'h80);
    host.wr(MIC_ADDR_STATUS, 8'hff);
    host.rd(MIC_ADDR_STATUS, d);
    chk(d, 8'h80);
    // Reset in mid-run
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    host.rd(MIC_ADDR_INT_EN, d);
    chk(d, 8'h3f);
    host.rd(MIC_ADDR_AXIS, d);
    chk(d, 8'h07);
    host.rd(MIC_ADDR_LOW, d);
    chk(d, 8'h00);
    host.rd(MIC_ADDR_HIGH, d);
    chk(d, 8'h00);
    host.rd(MIC_ADDR_STATUS, d);
    chk(d, 8'h00);
    chk({dataOut.z, dataOut.x}, 16'h0000);
    chk(dataOut.y, 8'h00);
    chk(dataOut.res, 14'h0000);
    chk({intPin, dataReadyPin}, 2'b00);
    conclude();
  end
endmodule
`default_nettype wire

// *** tb/mic_host_model.sv ***
// Host side of the register port: single-byte writes and reads.
// Assumes clk_sys is shared with the device; tasks are called by the bench.
`default_nettype none
module mic_host_model (
  input wire logic clk_sys,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  // Byte write, bus scrambled on release
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdata;
  endtask
endmodule
`default_nettype wire
